// ### hw/bmct_pkg.sv
// package: constants and types of the block move and cycle timing block
package bmct_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register file layout
    localparam int unsigned NREG    = 8;
    localparam logic [2:0]  CNT_REG = 3'h4;
    localparam logic [2:0]  SRC_REG = 3'h5;
    localparam logic [2:0]  DST_REG = 3'h6;
    localparam logic [31:0] GR_RST  = 32'h0000_0000;
    ////////////////////////////////////////////////////////////////////////
    // data buffer
    localparam int unsigned FIFO_W    = 8;
    localparam int unsigned FIFO_D    = 32;
    localparam int unsigned FIFO_SLACK = 2;
    ////////////////////////////////////////////////////////////////////////
    // state counts, one state per clock period
    localparam logic [17:0] BM_HEAD   = 18'h00004;
    localparam logic [7:0]  C_ONE     = 8'h01;
    localparam logic [7:0]  C_TWO     = 8'h02;
    localparam logic [7:0]  C_FOUR    = 8'h04;
    localparam logic [7:0]  C3_BASE   = 8'h03;
    localparam logic [7:0]  C6_BASE   = 8'h06;
    localparam logic [7:0]  LDM_BASE  = 8'h03;
    localparam logic [2:0]  LDM_MIN   = 3'h2;
    localparam logic [2:0]  LDM_MAX   = 3'h4;
    localparam logic [7:0]  EXR_EXTRA = 8'h01;
    ////////////////////////////////////////////////////////////////////////
    // condition code layout
    localparam int unsigned H_BIT_W   = 11;
    localparam int unsigned H_BIT_L   = 27;
    localparam int unsigned WORD_SH   = 16;
    localparam int unsigned CCR_H     = 5;
    localparam int unsigned CCR_N     = 3;
    localparam int unsigned CCR_Z     = 2;
    localparam int unsigned CCR_V     = 1;
    localparam int unsigned CCR_C     = 0;
    localparam logic [7:0]  CCR_RST   = 8'h80;
    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} bmct_size_e;
    typedef enum logic [1:0] {K_FETCH = 2'h0, K_BYTE = 2'h1, K_WORD = 2'h2, K_INTERNAL = 2'h3} bmct_kind_e;
    typedef enum logic [2:0] {
        A_ONCHIP = 3'h0, A_SUP8 = 3'h1, A_SUP16 = 3'h2, A_EXT8_2 = 3'h3,
        A_EXT8_3 = 3'h4, A_EXT16_2 = 3'h5, A_EXT16_3 = 3'h6
    } bmct_area_e;
    typedef enum logic [2:0] {
        F_NONE = 3'h0, F_ADDW = 3'h1, F_SUBW = 3'h2, F_ADDL = 3'h3,
        F_SUBL = 3'h4, F_ADDXW = 3'h5, F_DIVU = 3'h6, F_DIVS = 3'h7
    } bmct_fop_e;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001, S_HEAD = 4'b0010, S_LOOP = 4'b0100, S_TAIL = 4'b1000
    } bmct_state_e;
endpackage

// ### hw/bmct_stream_if.sv
// interface: byte stream between the move engine and its buffer
`timescale 1ns/10ps
interface bmct_stream_if #(parameter int unsigned W = 8);
    logic         in_valid;
    logic [W-1:0] in_data;
    logic         in_ready;
    logic         in_afull;
    logic         out_valid;
    logic [W-1:0] out_data;
    logic         out_ready;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, in_afull, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, in_afull, out_valid, out_data);
endinterface

// ### hw/bmct_fifo.sv
// module: parameterised byte buffer between memory read and write
`timescale 1ns/10ps
module bmct_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned D     = 32,
    parameter int unsigned SLACK = 2
) (
    // clock, reset, enable
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic ce_in,
    // stream
    bmct_stream_if.fifo s
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    assign push        = s.in_valid && s.in_ready;
    assign pop         = s.out_valid && s.out_ready;
    assign s.in_ready  = (cnt != (AW+1)'(D));
    // afull leaves room for reads already in flight
    assign s.in_afull  = (cnt >= (AW+1)'(D - SLACK));
    assign s.out_valid = (cnt != '0);
    assign s.out_data  = mem[rp];

    always_ff @(posedge clk_in) begin
        if (ce_in && push) begin
            mem[wp] <= s.in_data;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else if (ce_in) begin
            if (push) begin
                wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
            end
            if (pop) begin
                rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
            end
            case ({push, pop})
                2'b10:   cnt <= cnt + 1'b1;
                2'b01:   cnt <= cnt - 1'b1;
                default: cnt <= cnt;
            endcase
        end
    end

    fifo_bound_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cnt <= (AW+1)'(D)) else $error("buffer count above depth");
endmodule // bmct_fifo

// ### hw/bmct_core.sv
// module: block move engine, register file, condition flags and state costs
`timescale 1ns/10ps
// Behaviour
// - byte move copies until byte counter zero
// - word move uses 16-bit counter, skips zero
// - move takes four plus two per byte
// - multi-register save takes 7, 9, 11
// - half carry from bit 11 or 27
// - zero result keeps Z, else clear
// - divide sets Z for zero divisor
// - divide N from divisor or quotient sign
// - extended control register adds one state
// - on-chip fetch and internal ops one state
// - module or external paths cost more states
// - three-state external adds wait states
// - unaffected flags hold, move keeps flags
// - eight wide registers with half aliases
// - one state equals one clock period
module bmct_core #(
    parameter int unsigned FIFO_DEPTH = bmct_pkg::FIFO_D
) (
    // clock, reset, enable
    input  wire logic                   clk_in,
    input  wire logic                   resetn_in,
    input  wire logic                   ce_in,
    // block move command
    input  wire logic                   start_in,
    input  wire logic                   word_form_in,
    output logic                        busy_out,
    output logic                        done_out,
    output logic [17:0]                 states_out,
    // memory port
    output logic                        mem_rd_out,
    output logic [31:0]                 mem_raddr_out,
    input  wire logic [7:0]             mem_rdata_in,
    output logic                        mem_wr_out,
    output logic [31:0]                 mem_waddr_out,
    output logic [7:0]                  mem_wdata_out,
    input  wire logic                   mem_wstall_in,
    // register file access
    input  wire logic                   rf_wr_in,
    input  wire logic [2:0]             rf_sel_in,
    input  wire bmct_pkg::bmct_size_e   rf_size_in,
    input  wire logic                   rf_upper_in,
    input  wire logic [31:0]            rf_wdata_in,
    output logic [31:0]                 rf_rdata_out,
    // condition flags
    input  wire bmct_pkg::bmct_fop_e    fop_in,
    input  wire logic [31:0]            opa_in,
    input  wire logic [31:0]            opb_in,
    input  wire logic                   ccr_wr_in,
    input  wire logic [7:0]             ccr_wdata_in,
    output logic [7:0]                  ccr_out,
    // state costs
    input  wire bmct_pkg::bmct_kind_e   kind_in,
    input  wire bmct_pkg::bmct_area_e   area_in,
    input  wire logic [3:0]             wait_in,
    output logic [7:0]                  cost_out,
    input  wire logic [2:0]             mreg_cnt_in,
    input  wire logic                   exr_valid_in,
    output logic [7:0]                  mreg_states_out
);
    import bmct_pkg::*;

    bmct_state_e  state;
    logic [31:0]  gr [NREG];
    logic         word_form;
    logic [17:0]  el;
    logic         rd_pend;
    logic         rd_issue;
    logic         wr_issue;
    logic         work_left;
    logic [15:0]  rem;
    logic [15:0]  start_n;
    logic [7:0]   next_ccr;
    logic         sub_op;
    logic         cx;
    logic [31:0]  ua;
    logic [31:0]  ub;
    logic [32:0]  sum;
    logic [31:0]  mag_a;
    logic [15:0]  mag_b;

    bmct_stream_if #(.W(FIFO_W)) st ();

    bmct_fifo #(.W(FIFO_W), .D(FIFO_DEPTH), .SLACK(FIFO_SLACK)) u_fifo (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .ce_in     (ce_in),
        .s         (st)
    );

    ////////////////////////////////////////////////////////////////////////
    // move datapath
    assign rem     = word_form ? gr[CNT_REG][15:0] : {8'h00, gr[CNT_REG][7:0]};
    assign start_n = word_form_in ? gr[CNT_REG][15:0] : {8'h00, gr[CNT_REG][7:0]};
    // reads every other state; afull holds them off when writes stall
    assign rd_issue = (state == S_LOOP) && (rem != 16'h0) && !mem_rd_out
                      && st.in_ready && !st.in_afull;
    assign wr_issue = st.out_valid && !mem_wstall_in;
    assign work_left = (rem != 16'h0) || mem_rd_out || rd_pend || st.out_valid;
    assign st.in_valid  = rd_pend;
    assign st.in_data   = mem_rdata_in;
    assign st.out_ready = !mem_wstall_in;

    ////////////////////////////////////////////////////////////////////////
    // move sequencer
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state      <= S_IDLE;
            busy_out   <= 1'b0;
            done_out   <= 1'b0;
            word_form  <= 1'b0;
            states_out <= '0;
            el         <= '0;
        end else if (ce_in) begin
            done_out <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_in) begin
                        word_form  <= word_form_in;
                        states_out <= BM_HEAD + {1'b0, start_n, 1'b0};
                        el         <= 18'h00001;
                        busy_out   <= 1'b1;
                        state      <= S_HEAD;
                    end
                end
                S_HEAD: begin
                    el    <= el + 18'h00001;
                    state <= S_LOOP;
                end
                S_LOOP, S_TAIL: begin
                    // finish only once the full state count has elapsed
                    if (!work_left && el >= states_out) begin
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        state    <= S_IDLE;
                    end else begin
                        el <= el + 18'h00001;
                        if (!work_left) begin
                            state <= S_TAIL;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_rd_out    <= 1'b0;
            mem_raddr_out <= '0;
            rd_pend       <= 1'b0;
        end else if (ce_in) begin
            mem_rd_out <= rd_issue;
            rd_pend    <= mem_rd_out;
            if (rd_issue) begin
                mem_raddr_out <= gr[SRC_REG];
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_wr_out    <= 1'b0;
            mem_waddr_out <= '0;
            mem_wdata_out <= '0;
        end else if (ce_in) begin
            mem_wr_out <= wr_issue;
            if (wr_issue) begin
                mem_waddr_out <= gr[DST_REG];
                mem_wdata_out <= st.out_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general registers
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] w, bmct_size_e sz, logic up);
        if (sz == SZ_BYTE) begin
            merge = up ? {o[31:16], w[7:0], o[7:0]} : {o[31:8], w[7:0]};
        end else if (sz == SZ_WORD) begin
            merge = up ? {w[15:0], o[15:0]} : {o[31:16], w[15:0]};
        end else begin
            merge = w;
        end
    endfunction

    function automatic logic [31:0] view(logic [31:0] r, bmct_size_e sz, logic up);
        if (sz == SZ_BYTE) begin
            view = {24'h000000, up ? r[15:8] : r[7:0]};
        end else if (sz == SZ_WORD) begin
            view = {16'h0000, up ? r[31:16] : r[15:0]};
        end else begin
            view = r;
        end
    endfunction

    // software writes are ignored while a move owns the counter and pointers
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                gr[i] <= GR_RST;
            end else if (ce_in) begin
                if (busy_out) begin
                    if (3'(i) == SRC_REG && rd_issue) begin
                        gr[i] <= gr[i] + 32'h1;
                    end else if (3'(i) == DST_REG && wr_issue) begin
                        gr[i] <= gr[i] + 32'h1;
                    end else if (3'(i) == CNT_REG && rd_issue) begin
                        gr[i] <= word_form ? {gr[i][31:16], gr[i][15:0] - 16'h1}
                                           : {gr[i][31:8], gr[i][7:0] - 8'h1};
                    end
                end else if (rf_wr_in && rf_sel_in == 3'(i)) begin
                    gr[i] <= merge(gr[i], rf_wdata_in, rf_size_in, rf_upper_in);
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rf_rdata_out <= '0;
        end else if (ce_in) begin
            rf_rdata_out <= view(gr[rf_sel_in], rf_size_in, rf_upper_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // condition flags
    always_comb begin
        sub_op = (fop_in == F_SUBW) || (fop_in == F_SUBL);
        cx     = (fop_in == F_ADDXW) && ccr_out[CCR_C];
        // words ride in the upper half so one adder serves both sizes
        if (fop_in == F_ADDW || fop_in == F_SUBW || fop_in == F_ADDXW) begin
            ua = {opa_in[15:0], 16'h0000};
            ub = {opb_in[15:0], 16'h0000};
        end else begin
            ua = opa_in;
            ub = opb_in;
        end
        sum = sub_op ? {1'b0, ua} - {1'b0, ub} : {1'b0, ua} + {1'b0, ub} + {16'h0000, cx, 16'h0000};
        mag_a = opa_in[31] ? 32'h0 - opa_in : opa_in;
        mag_b = opb_in[15] ? 16'h0 - opb_in[15:0] : opb_in[15:0];
        next_ccr = ccr_out;
        case (fop_in)
            F_ADDW, F_SUBW, F_ADDL, F_SUBL, F_ADDXW: begin
                next_ccr[CCR_H] = ua[H_BIT_L+1] ^ ub[H_BIT_L+1] ^ sum[H_BIT_L+1];
                next_ccr[CCR_N] = sum[31];
                next_ccr[CCR_V] = (ua[31] == (ub[31] ^ sub_op)) && (sum[31] != ua[31]);
                next_ccr[CCR_C] = sum[32];
                if (fop_in == F_ADDXW) begin
                    next_ccr[CCR_Z] = (sum[31:0] == 32'h0) && ccr_out[CCR_Z];
                end else begin
                    next_ccr[CCR_Z] = (sum[31:0] == 32'h0);
                end
            end
            F_DIVU: begin
                next_ccr[CCR_Z] = (opb_in[15:0] == 16'h0);
                next_ccr[CCR_N] = opb_in[15];
            end
            F_DIVS: begin
                next_ccr[CCR_Z] = (opb_in[15:0] == 16'h0);
                next_ccr[CCR_N] = (opa_in[31] ^ opb_in[15]) && (mag_b != 16'h0)
                                  && (mag_a >= {16'h0000, mag_b});
            end
            default: begin
                if (ccr_wr_in) begin
                    next_ccr = ccr_wdata_in;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ccr_out <= CCR_RST;
        end else if (ce_in) begin
            ccr_out <= next_ccr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state costs
    function automatic logic [7:0] cycle_cost(bmct_kind_e k, bmct_area_e a, logic [3:0] m);
        logic [7:0] m8;
        logic       wide;
        m8   = {4'h0, m};
        wide = (k != K_BYTE);
        if (k == K_INTERNAL || a == A_ONCHIP) begin
            cycle_cost = C_ONE;
        end else if (a == A_SUP16 || a == A_EXT16_2) begin
            cycle_cost = C_TWO;
        end else if (a == A_EXT16_3) begin
            cycle_cost = C3_BASE + m8;
        end else if (a == A_EXT8_3) begin
            cycle_cost = wide ? C6_BASE + {m8[6:0], 1'b0} : C3_BASE + m8;
        end else begin
            cycle_cost = wide ? C_FOUR : C_TWO;
        end
    endfunction

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cost_out        <= '0;
            mreg_states_out <= '0;
        end else if (ce_in) begin
            cost_out <= cycle_cost(kind_in, area_in, wait_in);
            if (mreg_cnt_in >= LDM_MIN && mreg_cnt_in <= LDM_MAX) begin
                mreg_states_out <= LDM_BASE + {4'h0, mreg_cnt_in, 1'b0}
                                   + (exr_valid_in ? EXR_EXTRA : 8'h00);
            end else begin
                mreg_states_out <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [17:0] busy_len;
    logic        stall_seen;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_len   <= '0;
            stall_seen <= 1'b0;
        end else if (ce_in) begin
            if (state == S_IDLE && start_in) begin
                busy_len   <= '0;
                stall_seen <= 1'b0;
            end else if (busy_out) begin
                busy_len <= busy_len + 18'h00001;
                if (mem_wstall_in || st.in_afull) begin
                    stall_seen <= 1'b1;
                end
            end
        end
    end

    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    move_length_a: assert property ($fell(busy_out) |-> stall_seen || busy_len == states_out)
        else $error("move length differs from four plus two per byte");
    zero_skip_a: assert property ((state == S_IDLE && start_in && ce_in && start_n == 16'h0)
        |=> !mem_rd_out [*4])
        else $error("read issued for zero count");
    src_step_a: assert property (mem_rd_out |-> gr[SRC_REG] == mem_raddr_out + 32'h1)
        else $error("source pointer not stepped");
    count_step_a: assert property ((rd_issue && ce_in) |=> rem == $past(rem) - 16'h1)
        else $error("counter not decremented");
    half_carry_a: assert property ((fop_in == F_ADDW && ce_in) |=>
        ccr_out[CCR_H] == ({1'b0, $past(opa_in[11:0])} + {1'b0, $past(opb_in[11:0])} > 13'h0fff))
        else $error("half carry wrong");
    zero_keep_a: assert property ((fop_in == F_ADDXW && ce_in && ccr_out[CCR_Z] == 1'b0) |=> !ccr_out[CCR_Z])
        else $error("zero flag set by extended add");
    div_zero_a: assert property ((fop_in == F_DIVU && ce_in) |=>
        ccr_out[CCR_Z] == ($past(opb_in[15:0]) == 16'h0) && ccr_out[CCR_N] == $past(opb_in[15]))
        else $error("divide flags wrong");
    flag_hold_a: assert property ((fop_in == F_NONE && !ccr_wr_in) |=> $stable(ccr_out))
        else $error("flags changed without cause");
    mreg_three_a: assert property ((mreg_cnt_in == 3'h3 && !exr_valid_in && ce_in) |=> mreg_states_out == 8'h09)
        else $error("three register count wrong");
    ext_word_a: assert property ((area_in == A_EXT8_3 && kind_in == K_WORD && ce_in) |=>
        cost_out == 8'h06 + {3'h0, $past(wait_in), 1'b0})
        else $error("external word cost wrong");

    move_byte_c: cover property (done_out && !word_form && states_out > BM_HEAD);
    move_word_c: cover property (done_out && word_form && states_out > BM_HEAD);
    move_zero_c: cover property (done_out && states_out == BM_HEAD);
    move_stall_c: cover property (busy_out && mem_wstall_in && st.in_afull);
endmodule // bmct_core

// ### bench/bmct_mem_model.sv
// memory partner: one-state reads, checks every written byte
`timescale 1ns/10ps
module bmct_mem_model #(parameter logic [7:0] DELTA = 8'h00) (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic [31:0] raddr_in,
    output logic [7:0]       rdata_out,
    input  wire logic        wr_in,
    input  wire logic [31:0] waddr_in,
    input  wire logic [7:0]  wdata_in,
    output int               wr_count,
    output int               bad_count
);
    initial rdata_out = 8'h00;
    initial wr_count = 0;
    initial bad_count = 0;
    // data only valid the state after the strobe; it toggles after that so a late sample shows
    always @(posedge clk_in) begin
        rdata_out <= rd_in ? (raddr_in[7:0] ^ 8'h5a) : ~rdata_out;
        if (wr_in) wr_count <= wr_count + 1;
        if (wr_in && wdata_in !== ((waddr_in[7:0] - DELTA) ^ 8'h5a)) bad_count <= bad_count + 1;
    end
endmodule // bmct_mem_model

// ### bench/block_move_and_cycle_timing_bench.sv
// bench: block move, flags, state costs and register views
`timescale 1ns/10ps
module block_move_and_cycle_timing_bench;
    import bmct_pkg::*;
    logic clk_in = 1'h0, resetn_in = 1'h0, ce_in = 1'h1, start_in = 1'h0, word_form_in = 1'h0;
    logic mem_wstall_in = 1'h0, rf_wr_in = 1'h0, rf_upper_in = 1'h0, ccr_wr_in = 1'h0, exr_valid_in = 1'h0;
    logic busy_out, done_out, mem_rd_out, mem_wr_out;
    logic [17:0] states_out;
    logic [31:0] mem_raddr_out, mem_waddr_out, rf_rdata_out, rf_wdata_in = 32'h0, opa_in = 32'h0, opb_in = 32'h0;
    logic [7:0]  mem_rdata_in, mem_wdata_out, ccr_out, cost_out, mreg_states_out, ccr_wdata_in = 8'h00;
    logic [2:0]  rf_sel_in = 3'h0, mreg_cnt_in = 3'h0;
    logic [3:0]  wait_in = 4'h0;
    bmct_size_e  rf_size_in = SZ_BYTE;
    bmct_fop_e   fop_in = F_NONE;
    bmct_kind_e  kind_in = K_FETCH;
    bmct_area_e  area_in = A_ONCHIP;
    int fail_count = 0, checked = 0, cycles = 0, wr_count, bad_count;
    bmct_core u_dut (.*);
    bmct_mem_model #(.DELTA(8'hf5)) u_mem (.clk_in(clk_in), .rd_in(mem_rd_out), .raddr_in(mem_raddr_out),
        .rdata_out(mem_rdata_in), .wr_in(mem_wr_out), .waddr_in(mem_waddr_out), .wdata_in(mem_wdata_out),
        .wr_count(wr_count), .bad_count(bad_count));
    ////////////////////////////////////////////////////////////////////////
    initial forever #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic tick(); @(posedge clk_in); #1; endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wreg(input logic [2:0] s, input bmct_size_e z, input logic u, input logic [31:0] d);
        rf_sel_in = s; rf_size_in = z; rf_upper_in = u; rf_wdata_in = d; rf_wr_in = 1'h1;
        tick();
        rf_wr_in = 1'h0;
        tick();
    endtask
    task automatic rreg(input logic [2:0] s, input bmct_size_e z, input logic u, input logic [31:0] e);
        rf_sel_in = s; rf_size_in = z; rf_upper_in = u;
        tick();
        chk(rf_rdata_out, e, "register view");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // stall holds writes for 149 states so the buffer reaches afull and reads are held off before draining
    task automatic move(input logic w, input logic [15:0] cnt, input logic stall);
        logic [15:0] n;
        logic [31:0] cyc;
        logic [7:0]  c0;
        int          w0;
        n = w ? cnt : {8'h00, cnt[7:0]};
        wreg(3'h4, SZ_WORD, 1'h0, {16'h0000, cnt});
        wreg(3'h5, SZ_LONG, 1'h0, 32'h0000_0110);
        wreg(3'h6, SZ_LONG, 1'h0, 32'h0000_0305);
        c0 = ccr_out; w0 = wr_count; word_form_in = w; start_in = 1'h1;
        tick();
        cyc = 0;
        while (done_out !== 1'h1 && cyc < 3000) begin
            cyc++;
            start_in = (cyc == 2); // a second start while busy must change nothing
            mem_wstall_in = stall && cyc < 150;
            tick();
        end
        mem_wstall_in = 1'h0;
        if (!stall) chk(cyc, 32'd4 + 2 * n, "move length");
        chk(busy_out, 1'h0, "busy after move");
        chk(states_out, 18'd4 + 2 * n, "state count");
        chk(wr_count - w0, n, "bytes written");
        chk(bad_count, 0, "byte content");
        chk(ccr_out, c0, "flags after move");
        rreg(3'h4, SZ_WORD, 1'h0, w ? 32'h0 : {16'h0, cnt[15:8], 8'h00});
        rreg(3'h5, SZ_LONG, 1'h0, 32'h0110 + n);
        rreg(3'h6, SZ_LONG, 1'h0, 32'h0305 + n);
        $display("move test done");
    endtask
    task automatic flag(input bmct_fop_e op, input logic [31:0] a, b, input logic [7:0] pre, m, e);
        ccr_wdata_in = pre; ccr_wr_in = 1'h1;
        tick();
        ccr_wr_in = 1'h0; fop_in = op; opa_in = a; opb_in = b;
        tick();
        fop_in = F_NONE;
        chk(ccr_out & m, e, "flags");
    endtask
    task automatic cost(input bmct_kind_e k, input bmct_area_e a, input logic [3:0] w, input logic [7:0] e);
        kind_in = k; area_in = a; wait_in = w;
        tick();
        chk(cost_out, e, "access cost");
    endtask
    task automatic mreg(input logic [2:0] c, input logic x, input logic [7:0] e);
        mreg_cnt_in = c; exr_valid_in = x;
        tick();
        chk(mreg_states_out, e, "save states");
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_in);
        #1 resetn_in = 1'h1;
        chk(ccr_out, 8'h80, "reset flags");
        rreg(3'h4, SZ_LONG, 1'h0, 32'h0);
        $display("reset test done");
        move(1'h0, 16'h0000, 1'h0);
        move(1'h0, 16'h7f03, 1'h0);
        move(1'h0, 16'h00ff, 1'h0);
        move(1'h1, 16'h0000, 1'h0);
        move(1'h1, 16'h0101, 1'h0);
        move(1'h1, 16'h0040, 1'h1);
        wreg(3'h2, SZ_LONG, 1'h0, 32'h1122_3344);
        rreg(3'h2, SZ_BYTE, 1'h1, 32'h33);
        rreg(3'h2, SZ_WORD, 1'h1, 32'h1122);
        wreg(3'h2, SZ_BYTE, 1'h1, 32'haa);
        rreg(3'h2, SZ_LONG, 1'h0, 32'h1122_aa44);
        $display("register test done");
        flag(F_NONE, 32'h0, 32'h0, 8'h5a, 8'hff, 8'h5a);
        flag(F_ADDW, 32'h0800, 32'h0800, 8'h00, 8'h20, 8'h20);
        flag(F_ADDW, 32'h0001, 32'h0001, 8'hff, 8'h20, 8'h00);
        flag(F_SUBW, 32'h1000, 32'h0001, 8'h00, 8'h20, 8'h20);
        flag(F_ADDL, 32'h0800_0000, 32'h0800_0000, 8'h00, 8'h20, 8'h20);
        flag(F_SUBL, 32'h1000_0000, 32'h0001, 8'h00, 8'h20, 8'h20);
        flag(F_ADDXW, 32'h0, 32'h0, 8'h04, 8'h04, 8'h04);
        flag(F_ADDXW, 32'h0, 32'h0, 8'h00, 8'h04, 8'h00);
        flag(F_ADDXW, 32'h1, 32'h0, 8'h04, 8'h04, 8'h00);
        flag(F_DIVU, 32'h10, 32'h0, 8'h00, 8'h04, 8'h04);
        flag(F_DIVU, 32'h10, 32'h8000, 8'h04, 8'h0c, 8'h08);
        flag(F_DIVS, 32'h10, 32'hfffe, 8'h00, 8'h0c, 8'h08);
        $display("flag test done");
        cost(K_FETCH, A_ONCHIP, 4'h0, 8'h01);
        cost(K_INTERNAL, A_EXT8_3, 4'h5, 8'h01);
        cost(K_BYTE, A_SUP8, 4'h0, 8'h02);
        cost(K_WORD, A_SUP8, 4'h0, 8'h04);
        cost(K_FETCH, A_SUP16, 4'h0, 8'h02);
        cost(K_WORD, A_EXT8_2, 4'h0, 8'h04);
        cost(K_FETCH, A_EXT16_2, 4'h0, 8'h02);
        cost(K_BYTE, A_EXT8_3, 4'h2, 8'h05);
        cost(K_WORD, A_EXT8_3, 4'hf, 8'h24);
        cost(K_FETCH, A_EXT16_3, 4'h3, 8'h06);
        mreg(3'h2, 1'h0, 8'h07);
        mreg(3'h3, 1'h0, 8'h09);
        mreg(3'h4, 1'h0, 8'h0b);
        mreg(3'h4, 1'h1, 8'h0c);
        ce_in = 1'h0;
        mreg_cnt_in = 3'h2;
        tick();
        chk(mreg_states_out, 8'h0c, "frozen by enable");
        ce_in = 1'h1;
        $display("cost test done");
        complete_run();
    end
endmodule // block_move_and_cycle_timing_bench
